// file: verilog/chensc_top.sv
`timescale 1ns/1ps
// Function
// - Clear register at offset 0x508, one bit per channel
// - Clear register read returns live enable state
// - Writing 1 to clear disables that channel
// - Writing 0 to clear changes nothing
// - Read 1 means enabled, 0 disabled
// - Bit n maps to channel n, 0 to 31
// - Set register at 0x504, write 1 enables
module chensc_top
   import chensc_pkg::*;
(
   input  wire logic        sys_clk_in,   // System clock, 250 MHz
   input  wire logic        rst_in,       // Sync reset, active high
   input  wire logic        wb_cyc_in,    // Wishbone cycle
   input  wire logic        wb_stb_in,    // Wishbone strobe
   input  wire logic        wb_we_in,     // Write enable
   input  wire logic [11:0] wb_adr_in,    // Byte address
   input  wire logic [3:0]  wb_sel_in,    // Byte lane selects
   input  wire logic [31:0] wb_dat_in,    // Write data
   output logic      [31:0] wb_dat_out,   // Read data
   output logic             wb_ack_out,   // Acknowledge
   output logic      [31:0] channel_enable_state_out      // Channel enable state
);
   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   chensc_state_t state_r;
   chensc_state_t state_nxt;
   logic [31:0]   rdata_r;
   logic [31:0]   rdata_nxt;
   logic [31:0]   lane_mask;
   logic [31:0]   set_vec;
   logic [31:0]   clr_vec;
   logic [31:0]   chan_en;
   logic          req;
   logic          wr_take;

   //------------------------------------------------------------
   // Bus decode
   //------------------------------------------------------------
   // Request seen only while idle, so each access acks once
   assign req     = wb_cyc_in && wb_stb_in && (state_r == CHENSC_IDLE);
   assign wr_take = req && wb_we_in;

   // Byte lane expansion of sel
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lane_mask[i*8 +: 8] = {8{wb_sel_in[i]}};
      end
   end

   // Strobes: only ones in selected lanes act
   always_comb begin
      set_vec = '0;
      clr_vec = '0;
      if (wr_take && (wb_adr_in == CHENSC_OFF_SET)) begin
         set_vec = wb_dat_in & lane_mask;
      end else if (wr_take && (wb_adr_in == CHENSC_OFF_CLR)) begin
         clr_vec = wb_dat_in & lane_mask;
      end
   end

   //------------------------------------------------------------
   // Channel enable storage
   //------------------------------------------------------------
   // One flop per channel, bit n is channel n
   for (genvar g = 0; g < CHENSC_NUM_CH; g++) begin : g_ch
      chensc_bit u_bit (
         .sys_clk_in (sys_clk_in),
         .rst_in     (rst_in),
         .set_in     (set_vec[g]),
         .clr_in     (clr_vec[g]),
         .en_out     (chan_en[g])
      );
   end

   //------------------------------------------------------------
   // Read data and acknowledge
   //------------------------------------------------------------
   // Both set and clear read the live enable vector
   always_comb begin
      state_nxt = CHENSC_IDLE;
      rdata_nxt = rdata_r;
      if (req) begin
         state_nxt = CHENSC_ACK;
         if (wb_adr_in == CHENSC_OFF_SET) begin
            rdata_nxt = chan_en;
         end else if (wb_adr_in == CHENSC_OFF_CLR) begin
            rdata_nxt = chan_en;
         end else if (wb_adr_in == CHENSC_OFF_STATE) begin
            rdata_nxt = chan_en;
         end else begin
            rdata_nxt = CHENSC_UNMAPPED_RD;
         end
      end
   end

   // Slave state and read data registers
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_r <= CHENSC_IDLE;
         rdata_r <= CHENSC_RST_ENABLE;
      end else begin
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign wb_ack_out = (state_r == CHENSC_ACK);
   assign wb_dat_out = rdata_r;
   assign channel_enable_state_out   = chan_en;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   a_clr_disables: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_CLR && wb_sel_in[0] && wb_dat_in[0]) |=> !channel_enable_state_out[0])
      else $error("clear write left channel 0 enabled");

   a_set_enables: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_SET && wb_sel_in[3] && wb_dat_in[31]) |=> channel_enable_state_out[31])
      else $error("set write left channel 31 disabled");

   a_zero_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_CLR && wb_dat_in == 32'h0000_0000)
      |=> channel_enable_state_out == $past(channel_enable_state_out))
      else $error("zero clear write changed channels");

   a_clr_reads_live: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (req && !wb_we_in && wb_adr_in == CHENSC_OFF_CLR) |=> wb_dat_out == $past(channel_enable_state_out))
      else $error("clear read differs from enable state");

   a_set_reads_live: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (req && !wb_we_in && wb_adr_in == CHENSC_OFF_SET) |=> wb_dat_out == $past(channel_enable_state_out))
      else $error("set read differs from enable state");

   a_clr_only_one: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_CLR && wb_sel_in == 4'hf && wb_dat_in == 32'h0200_0000)
      |=> channel_enable_state_out == ($past(channel_enable_state_out) & 32'hfdff_ffff))
      else $error("clear of channel 25 touched other bits");

   a_reset_zero: assert property (@(posedge sys_clk_in)
      ($past(rst_in) && !rst_in) |-> channel_enable_state_out == CHENSC_RST_ENABLE)
      else $error("channels not disabled after reset");

   a_ack_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
      else $error("ack not a single cycle pulse");

   //------------------------------------------------------------
   // Further checks on strobes, holds and bus behaviour
   //------------------------------------------------------------
   // Ack never stands two cycles
   a_ack_drops: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("ack stood longer than one cycle");

   // No ack without a request
   a_no_ack_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!(wb_cyc_in && wb_stb_in) && !wb_ack_out) |=> !wb_ack_out)
      else $error("ack without a request");

   // Every ack follows a request
   a_ack_has_req: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without a prior request");

   // Unmapped reads return the fixed value
   a_unmapped_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (req && !wb_we_in && wb_adr_in != CHENSC_OFF_SET && wb_adr_in != CHENSC_OFF_CLR
       && wb_adr_in != CHENSC_OFF_STATE) |=> wb_dat_out == CHENSC_UNMAPPED_RD)
      else $error("unmapped read returned nonzero");

   // Set write turns on every selected one
   a_set_lanes_on: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_SET)
      |=> (channel_enable_state_out & $past(wb_dat_in & lane_mask)) == $past(wb_dat_in & lane_mask))
      else $error("set write missed a channel");

   // Set write leaves unselected channels alone
   a_set_keeps_rest: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_SET)
      |=> (channel_enable_state_out & ~$past(set_vec)) == ($past(channel_enable_state_out) & ~$past(set_vec)))
      else $error("set write moved other channels");

   // Clear write turns off every selected one
   a_clr_lanes_off: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_CLR)
      |=> (channel_enable_state_out & $past(wb_dat_in & lane_mask)) == 32'h0000_0000)
      else $error("clear write missed a channel");

   // Clear write leaves unselected channels alone
   a_clr_keeps_rest: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_CLR)
      |=> (channel_enable_state_out | $past(clr_vec)) == ($past(channel_enable_state_out) | $past(clr_vec)))
      else $error("clear write moved other channels");

   // No strobe, no change in state
   a_idle_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (set_vec == 32'h0000_0000 && clr_vec == 32'h0000_0000) |=> $stable(channel_enable_state_out))
      else $error("channels changed with no strobe");

   // Reads never disturb the enables
   a_read_no_effect: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (req && !wb_we_in) |=> $stable(channel_enable_state_out))
      else $error("read changed channel state");

   // Plain view reads the live vector
   a_state_reads_live: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (req && !wb_we_in && wb_adr_in == CHENSC_OFF_STATE) |=> wb_dat_out == $past(channel_enable_state_out))
      else $error("plain view read differs from enable state");

   // Read data holds between accesses
   a_dat_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !req |=> $stable(wb_dat_out))
      else $error("read data moved without a request");

   // Bus outputs quiet after reset
   a_reset_bus: assert property (@(posedge sys_clk_in)
      ($past(rst_in) && !rst_in) |-> (!wb_ack_out && wb_dat_out == CHENSC_RST_ENABLE))
      else $error("bus outputs not cleared by reset");

   // Bit n of the output is channel n
   a_vec_order: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (wr_take && wb_adr_in == CHENSC_OFF_SET && wb_sel_in == 4'hf && wb_dat_in == 32'h0200_0000)
      |=> (channel_enable_state_out & 32'h0200_0000) == 32'h0200_0000)
      else $error("set of channel 25 missed bit 25");
endmodule

// file: verilog/chensc_pkg.sv
package chensc_pkg;
   //------------------------------------------------------------
   // Register map and layout
   //------------------------------------------------------------
   localparam int          CHENSC_NUM_CH      = 32;
   localparam int          CHENSC_AW          = 12;
   localparam logic [11:0] CHENSC_OFF_STATE   = 12'h500;  // Plain enable view
   localparam logic [11:0] CHENSC_OFF_SET     = 12'h504;
   localparam logic [11:0] CHENSC_OFF_CLR     = 12'h508;
   localparam logic [31:0] CHENSC_RST_ENABLE  = 32'h0000_0000;
   localparam logic [31:0] CHENSC_UNMAPPED_RD = 32'h0000_0000;

   // Slave answer states
   typedef enum logic [0:0] {
      CHENSC_IDLE = 1'b0,
      CHENSC_ACK  = 1'b1
   } chensc_state_t;
endpackage

// file: verilog/chensc_bit.sv
`timescale 1ns/1ps
//------------------------------------------------------------
// One channel enable flip-flop with set and clear strobes
//------------------------------------------------------------
module chensc_bit
   import chensc_pkg::*;
(
   input  wire logic sys_clk_in,  // System clock
   input  wire logic rst_in,      // Sync reset, active high
   input  wire logic set_in,      // Enable strobe
   input  wire logic clr_in,      // Disable strobe
   output logic      en_out       // Current enable state
);
   logic en_r;
   logic en_nxt;

   // Set enables, clear disables, neither holds
   always_comb begin
      en_nxt = en_r;
      if (set_in) begin
         en_nxt = 1'b1;
      end else if (clr_in) begin
         en_nxt = 1'b0;
      end
   end

   // Enable register
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         en_r <= 1'b0;
      end else begin
         en_r <= en_nxt;
      end
   end

   assign en_out = en_r;
endmodule

// file: sim/chensc_bench.sv
`timescale 1ns/1ps
module chensc_bench import chensc_pkg::*;;
   logic        sys_clk_in;
   logic        rst_in;
   logic        wb_cyc_in;
   logic        wb_stb_in;
   logic        wb_we_in;
   logic [11:0] wb_adr_in;
   logic [3:0]  wb_sel_in;
   logic [31:0] wb_dat_in;
   logic [31:0] wb_dat_out;
   logic        wb_ack_out;
   logic [31:0] channel_enable_state_out;
   logic [31:0] exp_en;
   logic [31:0] rd;
   int          fails;
   int          check_count;
   int          cycles;

   //------------------------------------------------------------
   // Device under test
   //------------------------------------------------------------
   chensc_top chensc_top_inst (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .wb_cyc_in  (wb_cyc_in),
      .wb_stb_in  (wb_stb_in),
      .wb_we_in   (wb_we_in),
      .wb_adr_in  (wb_adr_in),
      .wb_sel_in  (wb_sel_in),
      .wb_dat_in  (wb_dat_in),
      .wb_dat_out (wb_dat_out),
      .wb_ack_out (wb_ack_out),
      .channel_enable_state_out   (channel_enable_state_out)
   );

   //------------------------------------------------------------
   // Clock, timeout and reporting
   //------------------------------------------------------------
   // 250 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Hang guard, well above the few hundred cycles needed
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   //------------------------------------------------------------
   // Wishbone classic master
   //------------------------------------------------------------
   task automatic wb_cycle(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge sys_clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in  <= w;
      wb_adr_in <= a;
      wb_dat_in <= d;
      wb_sel_in <= s;
      do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
      rd = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask

   task automatic wb_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      wb_cycle(1'b1, a, d, s);
   endtask

   // Both views and the plain view must match the expected state
   task automatic chk_regs();
      wb_cycle(1'b0, CHENSC_OFF_SET, 32'h0000_0000, 4'hf);
      chk(rd, exp_en);
      wb_cycle(1'b0, CHENSC_OFF_CLR, 32'h0000_0000, 4'hf);
      chk(rd, exp_en);
      wb_cycle(1'b0, CHENSC_OFF_STATE, 32'h0000_0000, 4'hf);
      chk(rd, exp_en);
      chk(channel_enable_state_out, exp_en);
   endtask

   //------------------------------------------------------------
   // Test sequence
   //------------------------------------------------------------
   initial begin
      rst_in = 1'b1; wb_cyc_in = 1'b0; wb_stb_in = 1'b0; wb_we_in = 1'b0;
      wb_adr_in = 12'h000; wb_sel_in = 4'h0; wb_dat_in = 32'h0000_0000;
      fails = 0; check_count = 0; cycles = 0; rd = 32'h0000_0000;
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      exp_en = CHENSC_RST_ENABLE;
      chk_regs();
      wb_write(CHENSC_OFF_SET, 32'h8000_0001, 4'hf); exp_en = 32'h8000_0001;
      chk_regs();
      wb_write(CHENSC_OFF_SET, 32'ha55a_a55a, 4'hf); exp_en |= 32'ha55a_a55a;
      chk_regs();
      wb_write(CHENSC_OFF_CLR, 32'h0000_0000, 4'hf);
      chk_regs();
      wb_write(CHENSC_OFF_CLR, 32'h8000_0003, 4'hf); exp_en &= ~32'h8000_0003;
      chk_regs();
      // Byte lanes limit which channels move
      wb_write(CHENSC_OFF_SET, 32'hffff_ffff, 4'h2); exp_en |= 32'h0000_ff00;
      chk_regs();
      wb_write(CHENSC_OFF_CLR, 32'hffff_ffff, 4'h4); exp_en &= ~32'h00ff_0000;
      chk_regs();
      // Unmapped and read-only places leave the state alone
      wb_write(12'h50c, 32'hffff_ffff, 4'hf);
      wb_cycle(1'b0, 12'h50c, 32'h0000_0000, 4'hf);
      chk(rd, CHENSC_UNMAPPED_RD);
      wb_write(CHENSC_OFF_STATE, 32'hffff_ffff, 4'hf);
      chk_regs();
      // Walking one over every channel, back to back
      exp_en = 32'h0000_0000;
      wb_write(CHENSC_OFF_CLR, 32'hffff_ffff, 4'hf);
      for (int i = 0; i < 32; i++) begin
         wb_write(CHENSC_OFF_SET, 32'h0000_0001 << i, 4'hf);
         chk(channel_enable_state_out, 32'h0000_0001 << i);
         wb_write(CHENSC_OFF_CLR, 32'h0000_0001 << i, 4'hf);
         wb_cycle(1'b0, CHENSC_OFF_CLR, 32'h0000_0000, 4'hf);
         chk(rd, exp_en);
      end
      final_report();
   end
endmodule
